// [logic/sep_pkg.sv]
// Shared constants, types and helpers of the serial EEPROM read and protect link.
package sep_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Memory organisation.
   localparam int unsigned ADDR_W    = 11;
   localparam int unsigned MEM_WORDS = 2048;
   localparam logic [3:0]  DEV_CODE  = 4'ha;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing: the system clock and the serial clock that the host makes from it.
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned LINK_PERIOD_NS = 10000;
   // A least period, so the quarter rounds up.
   localparam int unsigned QTR_CYCLES =
      (LINK_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam logic [5:0]  QTR_LAST = 6'(QTR_CYCLES - 1);
   // Internal programming cycle, a least time, so it rounds up.
   localparam int unsigned PROG_TIME_NS = 5000000;
   localparam int unsigned PROG_CYCLES  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PROG_W       = 17;

   ////////////////////////////////////////////////////////////////////////////////
   // Device link states.
   typedef enum logic [3:0] {
      D_IDLE  = 4'h0,
      D_CTRL  = 4'h1,
      D_CACK  = 4'h2,
      D_WADDR = 4'h3,
      D_WACK  = 4'h4,
      D_WDATA = 4'h5,
      D_DACK  = 4'h6,
      D_RDATA = 4'h7,
      D_RACK  = 4'h8
   } sep_dev_state_t;

   // Host sequencer states.
   typedef enum logic [2:0] {
      H_IDLE  = 3'h0,
      H_START = 3'h1,
      H_CTRLW = 3'h2,
      H_ADDR  = 3'h3,
      H_DATA  = 3'h4,
      H_CTRLR = 3'h5,
      H_RD    = 3'h6,
      H_STOP  = 3'h7
   } sep_host_state_t;

   ////////////////////////////////////////////////////////////////////////////////
   // Control byte: type code, block select bits, direction (1 = read).
   function automatic logic [7:0] ctrl_byte(input logic [2:0] block_select_bits,
                                            input logic       rd);
      return {DEV_CODE, block_select_bits, rd};
   endfunction

   // True when a received control byte carries this device's type code.
   function automatic logic is_ours(input logic [7:0] b);
      return b[7:4] == DEV_CODE;
   endfunction

endpackage

// [logic/sep_if.sv]
// Two-wire link between the host end and the device end.
`timescale 1ns/10ps
interface sep_if;
   logic scl;
   logic sda_dev_out;
   logic sda_dev_oe;
   logic sda_host_out;
   logic sda_host_oe;
   wire  sda;

   // Open-drain wire: low while any enabled driver pulls low, else the pull-up wins.
   assign sda = ~((sda_dev_oe & ~sda_dev_out) | (sda_host_oe & ~sda_host_out));

   modport dev  (input scl, input sda, output sda_dev_out, output sda_dev_oe);
   modport host (output scl, input sda, output sda_host_out, output sda_host_oe);
endinterface

// [logic/sep_host.sv]
// Host end: makes the serial clock and runs byte write and read transfers.
`timescale 1ns/10ps
module sep_host (
   // Link.
   sep_if.host              link,
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Command.
   input  wire logic        cmd_valid,
   input  wire logic        cmd_read,
   input  wire logic        cmd_random,
   input  wire logic [10:0] cmd_addr,
   input  wire logic [7:0]  cmd_wdata,
   input  wire logic [7:0]  cmd_count,
   // Answer.
   output logic             busy,
   output logic [7:0]       rd_data,
   output logic             rd_valid,
   output logic             done,
   output logic             nack
);

   sep_pkg::sep_host_state_t state, next_state;
   logic [5:0]  tick, next_tick;
   logic [1:0]  q, next_q;
   logic [3:0]  bitn, next_bitn;
   logic [7:0]  sh, next_sh;
   logic [7:0]  remain, next_remain;
   logic [10:0] addr, next_addr;
   logic [7:0]  wdata, next_wdata;
   logic        rd, next_rd, rnd, next_rnd, again, next_again;
   logic        scl, next_scl, oe, next_oe;
   logic        next_busy, next_rd_valid, next_done, next_nack;
   logic [7:0]  next_rd_data;
   logic        sda_s1, sda_s2;
   logic        step, slot_end, tx_state;

   assign link.scl          = scl;
   assign link.sda_host_oe  = oe;
   assign link.sda_host_out = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Each bit is one slot of four quarters: clock low, data change, clock high twice.
   always_comb begin
      step     = tick == sep_pkg::QTR_LAST;
      slot_end = step && q == 2'h3;
      tx_state = state == sep_pkg::H_CTRLW || state == sep_pkg::H_ADDR ||
                 state == sep_pkg::H_DATA  || state == sep_pkg::H_CTRLR;
      next_state    = state;
      next_tick     = step ? 6'h00 : tick + 6'h01;
      next_q        = step ? q + 2'h1 : q;
      next_bitn     = bitn;
      next_sh       = sh;
      next_remain   = remain;
      next_addr     = addr;
      next_wdata    = wdata;
      next_rd       = rd;
      next_rnd      = rnd;
      next_again    = again;
      next_oe       = oe;
      next_busy     = busy;
      next_rd_data  = rd_data;
      next_rd_valid = 1'b0;
      next_done     = 1'b0;
      next_nack     = nack;
      // Data moves only in the second quarter, while the clock is low.
      if (step && q == 2'h0) begin
         case (state)
            sep_pkg::H_START: next_oe = 1'b0;
            sep_pkg::H_STOP:  next_oe = 1'b1;
            sep_pkg::H_RD:    next_oe = bitn == 4'h8 && remain != 8'h01;
            default:          next_oe = tx_state && bitn != 4'h8 && !sh[7];
         endcase
      end
      // Start and stop are the only edges made while the clock is high.
      if (step && q == 2'h2) begin
         if (state == sep_pkg::H_START) begin
            next_oe = 1'b1;
         end else if (state == sep_pkg::H_STOP) begin
            next_oe = 1'b0;
         end
      end
      if (state == sep_pkg::H_IDLE) begin
         next_tick = 6'h00;
         next_q    = 2'h0;
         if (cmd_valid) begin
            next_state  = sep_pkg::H_START;
            next_busy   = 1'b1;
            next_nack   = 1'b0;
            next_again  = 1'b0;
            next_rd     = cmd_read;
            next_rnd    = cmd_random;
            next_addr   = cmd_addr;
            next_wdata  = cmd_wdata;
            next_remain = cmd_count == 8'h00 ? 8'h01 : cmd_count;
         end
      end else if (slot_end) begin
         next_bitn = 4'h0;
         case (state)
            sep_pkg::H_START: begin
               // A repeated start leads to the read control byte.
               if (again || (rd && !rnd)) begin
                  next_state = sep_pkg::H_CTRLR;
                  next_sh    = sep_pkg::ctrl_byte(addr[10:8], 1'b1);
               end else begin
                  next_state = sep_pkg::H_CTRLW;
                  next_sh    = sep_pkg::ctrl_byte(addr[10:8], 1'b0);
               end
            end
            sep_pkg::H_RD: begin
               if (bitn != 4'h8) begin
                  next_sh   = {sh[6:0], sda_s2};
                  next_bitn = bitn + 4'h1;
                  if (bitn == 4'h7) begin
                     next_rd_data  = {sh[6:0], sda_s2};
                     next_rd_valid = 1'b1;
                  end
               end else begin
                  next_remain = remain - 8'h01;
                  next_state  = remain == 8'h01 ? sep_pkg::H_STOP : sep_pkg::H_RD;
               end
            end
            sep_pkg::H_STOP: begin
               next_state = sep_pkg::H_IDLE;
               next_busy  = 1'b0;
               next_done  = 1'b1;
            end
            default: begin
               if (bitn != 4'h8) begin
                  next_sh   = {sh[6:0], 1'b0};
                  next_bitn = bitn + 4'h1;
               end else if (sda_s2) begin
                  // No acknowledge: give up and close the bus.
                  next_nack  = 1'b1;
                  next_state = sep_pkg::H_STOP;
               end else begin
                  case (state)
                     sep_pkg::H_CTRLW: begin
                        next_state = sep_pkg::H_ADDR;
                        next_sh    = addr[7:0];
                     end
                     sep_pkg::H_ADDR: begin
                        // The address is loaded inside a write before a read.
                        if (rd) begin
                           next_again = 1'b1;
                           next_state = sep_pkg::H_START;
                        end else begin
                           next_state = sep_pkg::H_DATA;
                           next_sh    = wdata;
                        end
                     end
                     sep_pkg::H_CTRLR: next_state = sep_pkg::H_RD;
                     default:          next_state = sep_pkg::H_STOP;
                  endcase
               end
            end
         endcase
      end
      // Back in idle the clock stays high; a one-cycle low pulse after a stop would clock
      // the device again and break the low-phase timing.
      next_scl = next_state == sep_pkg::H_IDLE ? 1'b1 : next_q[1];
   end

   // Registers, plus a two-stage synchroniser on the returning data line.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= sep_pkg::H_IDLE;
         tick     <= 6'h00;
         q        <= 2'h0;
         bitn     <= 4'h0;
         sh       <= 8'h00;
         remain   <= 8'h00;
         addr     <= 11'h000;
         wdata    <= 8'h00;
         rd       <= 1'b0;
         rnd      <= 1'b0;
         again    <= 1'b0;
         scl      <= 1'b1;
         oe       <= 1'b0;
         busy     <= 1'b0;
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
         done     <= 1'b0;
         nack     <= 1'b0;
         sda_s1   <= 1'b1;
         sda_s2   <= 1'b1;
      end else begin
         state    <= next_state;
         tick     <= next_tick;
         q        <= next_q;
         bitn     <= next_bitn;
         sh       <= next_sh;
         remain   <= next_remain;
         addr     <= next_addr;
         wdata    <= next_wdata;
         rd       <= next_rd;
         rnd      <= next_rnd;
         again    <= next_again;
         scl      <= next_scl;
         oe       <= next_oe;
         busy     <= next_busy;
         rd_data  <= next_rd_data;
         rd_valid <= next_rd_valid;
         done     <= next_done;
         nack     <= next_nack;
         sda_s1   <= link.sda;
         sda_s2   <= sda_s1;
      end
   end

endmodule

// [logic/sep_dev.sv]
// Device end: two-wire EEPROM slave with reads, pointer and write protection.
// Functional notes
// - Host loads address inside a write first.
// - Repeated start ends write, pointer is kept.
// - Read control byte acked, pointer byte shifted out.
// - No host acknowledge then stop ends transmission.
// - Host acknowledge requests the next sequential byte.
// - Pointer increments by one after each byte.
// - Data changes only while the clock is low.
// - Data line is open drain, pull low only.
// - Protect low: reads and writes everywhere allowed.
// - Protect high: writes blocked, reads unchanged.
// - Unused address pins have no effect at all.
// - Acknowledge only the type code; block bits extend address.
// - No acknowledges during the programming cycle.
// - On missing host acknowledge, release the line.
// - Current read returns previous access address plus one.
`timescale 1ns/10ps
module sep_dev #(
   parameter int unsigned PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
   // Link.
   sep_if.dev               link,
   // System clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Pins.
   input  wire logic        wp,
   input  wire logic [2:0]  unused_address_pins,
   // Status.
   output logic             prog_busy
);

   ////////////////////////////////////////////////////////////////////////////////
   // Link-side state, clocked on the falling edge of the serial clock.
   sep_pkg::sep_dev_state_t state, next_state;
   logic [2:0]  cnt, next_cnt;
   logic [7:0]  sh, next_sh;
   logic [7:0]  tx, next_tx;
   logic [10:0] ptr, next_ptr;
   logic [2:0]  blk, next_blk;
   logic        rw, next_rw;
   logic        oe, next_oe;
   logic        lvl;
   logic        wrote, next_wrote;
   logic        pend, next_pend;
   logic        go_tgl, next_go_tgl;
   logic        start_seen, next_start_seen;
   logic        stop_seen, next_stop_seen;
   logic        done_seen, next_done_seen;
   logic        wp_s1, wp_s2, done_s1, done_s2;
   logic        sda_p;
   logic        mem_we;
   logic [7:0]  byte_in;
   logic [7:0]  mem [sep_pkg::MEM_WORDS];
   // Start and stop catchers, clocked by the data line itself.
   logic        start_tgl, next_start_tgl, stop_tgl, next_stop_tgl;
   // System-side programming timer.
   logic        go_s1, go_s2, go_seen, next_go_seen;
   logic        done_tgl, next_done_tgl, next_prog_busy;
   logic [sep_pkg::PROG_W-1:0] prog_cnt, next_prog_cnt;

   // The address pins are left unconnected inside: nothing reads them.

   // Open-drain output: the level is always low, only the enable moves.
   assign link.sda_dev_oe  = oe;
   assign link.sda_dev_out = lvl;

   ////////////////////////////////////////////////////////////////////////////////
   // Any data edge while the clock is high is a start (falling) or stop (rising).
   always_comb begin
      next_start_tgl = start_tgl ^ link.scl;
      next_stop_tgl  = stop_tgl ^ link.scl;
   end

   always_ff @(negedge link.sda or negedge rst_n) begin
      if (!rst_n) begin
         start_tgl <= 1'b0;
      end else begin
         start_tgl <= next_start_tgl;
      end
   end

   always_ff @(posedge link.sda or negedge rst_n) begin
      if (!rst_n) begin
         stop_tgl <= 1'b0;
      end else begin
         stop_tgl <= next_stop_tgl;
      end
   end

   // Data is sampled on the rising edge of the clock, when it must be stable.
   always_ff @(posedge link.scl or negedge rst_n) begin
      if (!rst_n) begin
         sda_p <= 1'b1;
      end else begin
         sda_p <= link.sda;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Byte engine. The start and stop toggles are read without a synchroniser:
   // they settle a quarter of a clock period before the falling edge that looks at them,
   // which the bus hold times guarantee, and extra stages would eat address bits.
   always_comb begin
      byte_in         = {sh[6:0], sda_p};
      next_state      = state;
      next_cnt        = cnt;
      next_sh         = sh;
      next_tx         = tx;
      next_ptr        = ptr;
      next_blk        = blk;
      next_rw         = rw;
      next_oe         = oe;
      next_wrote      = wrote;
      next_pend       = pend;
      next_go_tgl     = go_tgl;
      next_start_seen = start_seen;
      next_stop_seen  = stop_seen;
      next_done_seen  = done_s2;
      mem_we          = 1'b0;
      // Programming done clears the busy flag; a new commit below still wins.
      if (done_s2 != done_seen) begin
         next_pend = 1'b0;
      end
      if (start_tgl != start_seen || stop_tgl != stop_seen) begin
         next_start_seen = start_tgl;
         next_stop_seen  = stop_tgl;
         next_oe         = 1'b0;
         next_cnt        = 3'h0;
         if (stop_tgl != stop_seen && wrote) begin
            next_pend   = 1'b1;
            next_go_tgl = ~go_tgl;
            next_wrote  = 1'b0;
         end
         // A start, repeated or not, always opens a control byte; the pointer stays.
         next_state = start_tgl != start_seen ? sep_pkg::D_CTRL : sep_pkg::D_IDLE;
      end else begin
         case (state)
            sep_pkg::D_CTRL: begin
               next_sh  = byte_in;
               next_cnt = cnt + 3'h1;
               if (cnt == 3'h7) begin
                  // Silent while programming or when the type code differs.
                  if (sep_pkg::is_ours(byte_in) && !next_pend) begin
                     next_oe    = 1'b1;
                     next_rw    = byte_in[0];
                     next_blk   = byte_in[3:1];
                     next_state = sep_pkg::D_CACK;
                  end else begin
                     next_state = sep_pkg::D_IDLE;
                  end
               end
            end
            sep_pkg::D_CACK: begin
               next_cnt = 3'h0;
               if (rw) begin
                  // Reads start at the pointer: the address just loaded, or one past the last access.
                  next_tx    = mem[ptr];
                  next_oe    = !mem[ptr][7];
                  next_state = sep_pkg::D_RDATA;
               end else begin
                  next_oe    = 1'b0;
                  next_state = sep_pkg::D_WADDR;
               end
            end
            sep_pkg::D_WADDR: begin
               next_sh  = byte_in;
               next_cnt = cnt + 3'h1;
               if (cnt == 3'h7) begin
                  next_ptr   = {blk, byte_in};
                  next_oe    = 1'b1;
                  next_state = sep_pkg::D_WACK;
               end
            end
            sep_pkg::D_WDATA: begin
               next_sh  = byte_in;
               next_cnt = cnt + 3'h1;
               if (cnt == 3'h7) begin
                  // With protection high the byte is acknowledged but never stored.
                  if (!wp_s2) begin
                     mem_we     = 1'b1;
                     next_wrote = 1'b1;
                  end
                  next_ptr   = ptr + 11'h001;
                  next_oe    = 1'b1;
                  next_state = sep_pkg::D_DACK;
               end
            end
            sep_pkg::D_WACK, sep_pkg::D_DACK: begin
               next_oe    = 1'b0;
               next_cnt   = 3'h0;
               next_state = sep_pkg::D_WDATA;
            end
            sep_pkg::D_RDATA: begin
               if (cnt == 3'h7) begin
                  // Byte done: free the line for the host's acknowledge.
                  next_oe    = 1'b0;
                  next_ptr   = ptr + 11'h001;
                  next_state = sep_pkg::D_RACK;
               end else begin
                  next_cnt = cnt + 3'h1;
                  next_tx  = {tx[6:0], 1'b0};
                  next_oe  = !tx[6];
               end
            end
            sep_pkg::D_RACK: begin
               next_cnt = 3'h0;
               if (!sda_p) begin
                  // Acknowledged: carry on with the next address.
                  next_tx    = mem[ptr];
                  next_oe    = !mem[ptr][7];
                  next_state = sep_pkg::D_RDATA;
               end else begin
                  // No acknowledge: line stays released for the stop.
                  next_state = sep_pkg::D_IDLE;
               end
            end
            default: begin
               next_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(negedge link.scl or negedge rst_n) begin
      if (!rst_n) begin
         state      <= sep_pkg::D_IDLE;
         cnt        <= 3'h0;
         sh         <= 8'h00;
         tx         <= 8'h00;
         ptr        <= 11'h000;
         blk        <= 3'h0;
         rw         <= 1'b0;
         oe         <= 1'b0;
         lvl        <= 1'b0;
         wrote      <= 1'b0;
         pend       <= 1'b0;
         go_tgl     <= 1'b0;
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
         done_seen  <= 1'b0;
         wp_s1      <= 1'b1;
         wp_s2      <= 1'b1;
         done_s1    <= 1'b0;
         done_s2    <= 1'b0;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         sh         <= next_sh;
         tx         <= next_tx;
         ptr        <= next_ptr;
         blk        <= next_blk;
         rw         <= next_rw;
         oe         <= next_oe;
         lvl        <= 1'b0;
         wrote      <= next_wrote;
         pend       <= next_pend;
         go_tgl     <= next_go_tgl;
         start_seen <= next_start_seen;
         stop_seen  <= next_stop_seen;
         done_seen  <= next_done_seen;
         wp_s1      <= wp;
         wp_s2      <= wp_s1;
         done_s1    <= done_tgl;
         done_s2    <= done_s1;
      end
   end

   // Array write; the array has no reset, like the cells it stands for.
   always_ff @(negedge link.scl) begin
      if (mem_we) begin
         mem[ptr] <= byte_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Programming timer on the free-running clock; the serial clock may stop.
   always_comb begin
      next_go_seen   = go_seen;
      next_prog_cnt  = prog_cnt;
      next_prog_busy = prog_busy;
      next_done_tgl  = done_tgl;
      if (go_s2 != go_seen) begin
         next_go_seen   = go_s2;
         next_prog_cnt  = sep_pkg::PROG_W'(PROG_CYCLES - 1);
         next_prog_busy = 1'b1;
      end else if (prog_busy) begin
         if (prog_cnt == '0) begin
            next_prog_busy = 1'b0;
            next_done_tgl  = ~done_tgl;
         end else begin
            next_prog_cnt = prog_cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         go_s1     <= 1'b0;
         go_s2     <= 1'b0;
         go_seen   <= 1'b0;
         prog_cnt  <= '0;
         prog_busy <= 1'b0;
         done_tgl  <= 1'b0;
      end else begin
         go_s1     <= go_tgl;
         go_s2     <= go_s1;
         go_seen   <= next_go_seen;
         prog_cnt  <= next_prog_cnt;
         prog_busy <= next_prog_busy;
         done_tgl  <= next_done_tgl;
      end
   end

endmodule

// [testbench/sep_checker.sv]
// Checker for the two-wire link between the host and device ends.
`timescale 1ns/10ps
module sep_checker (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Link.
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_dev_out,
   input wire logic sda_dev_oe,
   input wire logic sda_host_out,
   input wire logic sda_host_oe
);
   // A low phase of the serial clock is two quarters of a bit slot.
   localparam int LOW_CYC = 2 * sep_pkg::QTR_CYCLES;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   // A zero byte after an ack keeps the pull on for nine falls, never ten.
   sequence s_long_pull;
      sda_dev_oe [*8] ##1 sda_dev_oe ##1 sda_dev_oe;
   endsequence
   sequence s_low_phase;
      ##LOW_CYC $rose(scl);
   endsequence
   property p_open_drain; sda_dev_oe |-> !sda_dev_out; endproperty
   property p_dev_moves_low; $changed(sda_dev_oe) |-> !scl; endproperty
   property p_high_stable; scl && $past(scl) && $changed(sda) |-> $changed(sda_host_oe);
   endproperty
   property p_stop_free; scl && $rose(sda) |-> !sda_dev_oe; endproperty
   property p_start_free; scl && $fell(sda) |-> !sda_dev_oe; endproperty
   property p_short_pull; @(negedge scl) disable iff (!rst_n) not s_long_pull; endproperty
   property p_low_time; $fell(scl) |-> s_low_phase; endproperty
   property p_high_time; $rose(scl) |-> scl [*8]; endproperty
   a_open_drain: assert property (p_open_drain) else $error("device drives sda high");
   a_dev_moves_low: assert property (p_dev_moves_low) else $error("device moved, scl high");
   a_high_stable: assert property (p_high_stable) else $error("sda moved while scl high");
   a_stop_free: assert property (p_stop_free) else $error("device held sda at stop");
   a_start_free: assert property (p_start_free) else $error("device held sda at start");
   a_short_pull: assert property (p_short_pull) else $error("device kept sda low");
   a_low_time: assert property (p_low_time) else $error("scl low phase length wrong");
   a_high_time: assert property (p_high_time) else $error("scl high phase too short");
endmodule

// [testbench/tb_serial_eeprom_read_and_protect.sv]
// Bench: host and device ends joined; writes, reads, wrap and write protection.
`timescale 1ns/10ps
module tb_serial_eeprom_read_and_protect;
   logic        clk = 1'b0, rst_n = 1'b0, wp = 1'b0;
   logic        cmd_valid = 1'b0, cmd_read = 1'b0, cmd_random = 1'b0;
   logic [10:0] cmd_addr = 11'h000;
   logic [7:0]  cmd_wdata = 8'h00, cmd_count = 8'h00, rd_data;
   logic        busy, rd_valid, done, nack, prog_busy;
   logic [7:0]  got [$];
   int          mismatches = 0, samples_checked = 0;
   sep_if link ();
   sep_host i_sep_host (.link(link), .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_read(cmd_read), .cmd_random(cmd_random), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_count(cmd_count), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid),
      .done(done), .nack(nack));
   // Programming outlasts one control byte, so the command after a write is refused once,
   // yet ends during the retry's control byte, before its acknowledge; unused pins tied to an odd pattern.
   sep_dev #(.PROG_CYCLES(2500)) i_sep_dev (.link(link), .clk(clk), .rst_n(rst_n), .wp(wp),
      .unused_address_pins(3'h5), .prog_busy(prog_busy));
   sep_checker i_sep_checker (.clk(clk), .rst_n(rst_n), .scl(link.scl), .sda(link.sda),
      .sda_dev_out(link.sda_dev_out), .sda_dev_oe(link.sda_dev_oe),
      .sda_host_out(link.sda_host_out), .sda_host_oe(link.sda_host_oe));
   ////////////////////////////////////////
   // Collect every read byte the host hands back.
   always @(posedge clk) if (rd_valid === 1'b1) got.push_back(rd_data);
   task check(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %0t: got %h want %h", $time, g, e);
      end
   endtask
   // One command, waited on under a bound; e is high when the device is still programming.
   task run(input logic rd, input logic rnd, input logic [10:0] a, input logic [7:0] d,
            input logic [7:0] n, input logic e);
      int k;
      got.delete();
      @(posedge clk);
      {cmd_valid, cmd_read, cmd_random, cmd_addr, cmd_wdata, cmd_count} <= {1'b1, rd, rnd, a, d, n};
      @(posedge clk);
      cmd_valid <= 1'b0;
      for (k = 0; k < 20000 && done !== 1'b1; k++) @(negedge clk);
      check({7'h00, done}, 8'h01);
      check({6'h00, nack, prog_busy}, {6'h00, e, e});
   endtask
   task t_fill;
      run(1'b0, 1'b0, 11'h7ff, 8'h5a, 8'h01, 1'b0);
      run(1'b0, 1'b0, 11'h000, 8'hc3, 8'h01, 1'b1);
      run(1'b0, 1'b0, 11'h000, 8'hc3, 8'h01, 1'b0);
   endtask
   task t_seq_wrap;
      run(1'b1, 1'b1, 11'h7ff, 8'h00, 8'h02, 1'b1);
      run(1'b1, 1'b1, 11'h7ff, 8'h00, 8'h02, 1'b0);
      check(got[0], 8'h5a);
      check(got[1], 8'hc3);
   endtask
   task t_current;
      run(1'b1, 1'b1, 11'h7ff, 8'h00, 8'h01, 1'b0);
      run(1'b1, 1'b0, 11'h000, 8'h00, 8'h01, 1'b0);
      check(got[0], 8'hc3);
   endtask
   task t_protect;
      @(posedge clk);
      wp <= 1'b1;
      run(1'b0, 1'b0, 11'h000, 8'h11, 8'h01, 1'b0);
      run(1'b1, 1'b1, 11'h000, 8'h00, 8'h01, 1'b0);
      check(got[0], 8'hc3);
      @(posedge clk);
      wp <= 1'b0;
   endtask
   task stop_test;
      $display("checked %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////
   initial forever #25 clk = ~clk;
   // Expected run is about 2.5 ms; the guard allows well beyond that.
   initial begin
      #4000000;
      mismatches++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_fill();
      t_seq_wrap();
      t_current();
      t_protect();
      stop_test();
   end
endmodule
